// file: logic/dbs_sram.v
// two-port burst sram: one read port, one write port, shared address
// assumes the controller drives the input clock pair slow enough to be
// sampled by clk_i (at least four clk_i cycles per half link period)
`timescale 1ns/1ns
`default_nettype none
`include "dbs_consts.vh"
module dbs_sram (
   input  wire                clk_i,        // system clock, 50 MHz
   input  wire                rst_b_i,      // synchronous reset, low
   input  wire                kclk_i,       // input clock
   input  wire                kclk_n_i,     // complementary input clock
   input  wire                cclk_i,       // output clock
   input  wire                cclk_n_i,     // complementary output clock
   input  wire                single_clk_i, // high: k pair clocks output
   input  wire                pll_bypass_i, // high: 1.5 cycle latency
   input  wire [`DBS_AW-1:0]  addr_i,       // shared address bus
   input  wire                rd_sel_b_i,   // read port select, low
   input  wire                wr_sel_b_i,   // write port select, low
   input  wire [`DBS_DW-1:0]  wdata_i,      // write data, ddr
   output reg  [`DBS_DW-1:0]  rdata_o,      // read data, ddr
   output reg                 echo_strobe_pair_o,   // echo clock
   output reg                 echo_strobe_pair_n_o  // echo complement
);
   // ************************************************************
   // link edge detection
   // ************************************************************
   wire k_rise;            // rising edge of input clock
   wire kn_rise;           // rising edge of complement
   wire c_rise;            // rising edge of output clock
   wire cn_rise;           // rising edge of complement
   dbs_edge_sync u_k  (.clk_i(clk_i), .rst_b_i(rst_b_i),
                       .async_i(kclk_i),   .rise_o(k_rise));
   dbs_edge_sync u_kn (.clk_i(clk_i), .rst_b_i(rst_b_i),
                       .async_i(kclk_n_i), .rise_o(kn_rise));
   dbs_edge_sync u_c  (.clk_i(clk_i), .rst_b_i(rst_b_i),
                       .async_i(cclk_i),   .rise_o(c_rise));
   dbs_edge_sync u_cn (.clk_i(clk_i), .rst_b_i(rst_b_i),
                       .async_i(cclk_n_i), .rise_o(cn_rise));

   // ************************************************************
   // input pin synchronisers (two flops each)
   // ************************************************************
   reg [`DBS_AW-1:0] addr_m_q, addr_s_q;   // address sync
   reg               rsel_m_q, rsel_s_q;   // read select sync
   reg               wsel_m_q, wsel_s_q;   // write select sync
   reg [`DBS_DW-1:0] wd_m_q,   wd_s_q;     // write data sync
   reg               byp_m_q,  byp_s_q;    // bypass sync
   reg               sgl_m_q,  sgl_s_q;    // single clock sync
   // delay matching: pin data aligned with the edge pulses
   reg [`DBS_AW-1:0] addr_a_q;             // address, one more
   reg               rsel_a_q, wsel_a_q;   // selects, one more
   reg [`DBS_DW-1:0] wd_a_q;               // data, one more

   // sample pins, aligned to the edge detector pipeline
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         addr_m_q <= {`DBS_AW{1'b0}};
         addr_s_q <= {`DBS_AW{1'b0}};
         addr_a_q <= {`DBS_AW{1'b0}};
         rsel_m_q <= 1'b1;
         rsel_s_q <= 1'b1;
         rsel_a_q <= 1'b1;
         wsel_m_q <= 1'b1;
         wsel_s_q <= 1'b1;
         wsel_a_q <= 1'b1;
         wd_m_q   <= {`DBS_DW{1'b0}};
         wd_s_q   <= {`DBS_DW{1'b0}};
         wd_a_q   <= {`DBS_DW{1'b0}};
         byp_m_q  <= 1'b1;
         byp_s_q  <= 1'b1;
         sgl_m_q  <= 1'b0;
         sgl_s_q  <= 1'b0;
      end else begin
         addr_m_q <= addr_i;
         addr_s_q <= addr_m_q;
         addr_a_q <= addr_s_q;
         rsel_m_q <= rd_sel_b_i;
         rsel_s_q <= rsel_m_q;
         rsel_a_q <= rsel_s_q;
         wsel_m_q <= wr_sel_b_i;
         wsel_s_q <= wsel_m_q;
         wsel_a_q <= wsel_s_q;
         wd_m_q   <= wdata_i;
         wd_s_q   <= wd_m_q;
         wd_a_q   <= wd_s_q;
         byp_m_q  <= pll_bypass_i;
         byp_s_q  <= byp_m_q;
         sgl_m_q  <= single_clk_i;
         sgl_s_q  <= sgl_m_q;
      end
   end

   // ************************************************************
   // memory array: two words per location
   // ************************************************************
   reg [`DBS_DW-1:0] mem_lo [0:`DBS_DEPTH-1]; // first burst word
   reg [`DBS_DW-1:0] mem_hi [0:`DBS_DEPTH-1]; // second burst word

   // ************************************************************
   // input capture state
   // ************************************************************
   reg               wr_pend_q;  // write address taken, awaiting data
   reg [`DBS_AW-1:0] wr_addr_q;  // captured write address
   reg [`DBS_DW-1:0] wr_lo_q;    // first write word
   reg               commit_q;   // self-timed commit strobe
   reg [`DBS_AW-1:0] cm_addr_q;  // commit address
   reg [`DBS_DW-1:0] cm_lo_q;    // commit first word
   reg [`DBS_DW-1:0] cm_hi_q;    // commit second word
   reg               rd_go_q;    // read captured, start out
   reg [`DBS_AW-1:0] rd_addr_q;  // captured read address

   // forwarding: newest data for an address, incl. pending commit
   function [2*`DBS_DW-1:0] dbs_fetch;
      input [`DBS_AW-1:0] a;
      begin
         if (commit_q && cm_addr_q == a)
            dbs_fetch = {cm_hi_q, cm_lo_q};
         else
            dbs_fetch = {mem_hi[a], mem_lo[a]};
      end
   endfunction

   // k edge: read address and write first word; k# edge: write
   // address and second word (alternate edges, one bus)
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= {`DBS_AW{1'b0}};
         wr_lo_q   <= {`DBS_DW{1'b0}};
         commit_q  <= 1'b0;
         cm_addr_q <= {`DBS_AW{1'b0}};
         cm_lo_q   <= {`DBS_DW{1'b0}};
         cm_hi_q   <= {`DBS_DW{1'b0}};
         rd_go_q   <= 1'b0;
         rd_addr_q <= {`DBS_AW{1'b0}};
      end else begin
         commit_q <= 1'b0;
         rd_go_q  <= 1'b0;
         if (k_rise) begin
            // read port captured on k, own select
            if (!rsel_a_q) begin
               rd_go_q   <= 1'b1;
               rd_addr_q <= addr_a_q;
            end
            // write captured on previous k#: first data word on k
            wr_lo_q <= wd_a_q;
         end
         if (kn_rise) begin
            if (!wsel_a_q) begin
               wr_pend_q <= 1'b1;
               wr_addr_q <= addr_a_q;
            end else begin
               wr_pend_q <= 1'b0;
            end
            // second word of a pending write completes burst
            if (wr_pend_q) begin
               commit_q  <= 1'b1;
               cm_addr_q <= wr_addr_q;
               cm_lo_q   <= wr_lo_q;
               cm_hi_q   <= wd_a_q;
            end
         end
      end
   end

   // self-timed array write, no external pulse
   always @(posedge clk_i) begin
      if (commit_q) begin
         mem_lo[cm_addr_q] <= cm_lo_q;
         mem_hi[cm_addr_q] <= cm_hi_q;
      end
   end

   // ************************************************************
   // read output pipeline
   // ************************************************************
   reg [2:0]         pv_q;        // word0 due, slot = phases left - 1
   reg [`DBS_AW-1:0] pa_q [0:2];  // read address per slot
   reg               hi_q;        // second word due on next phase
   reg [`DBS_DW-1:0] rbuf_q;      // second word held for its phase
   wire o_rise  = sgl_s_q ? k_rise  : c_rise;
   wire on_rise = sgl_s_q ? kn_rise : cn_rise;
   wire any_ph  = o_rise | on_rise;
   // latency in phases, less one already spent if a phase shifts now
   wire [1:0] lat_w  = byp_s_q ? `DBS_LAT_FULL
                               : `DBS_LAT_SHORT;
   wire [1:0] slot_w = lat_w - 2'd1 - {1'b0, any_ph};

   // phase delay line: a new read may start while the last one is
   // still bursting; the array is read as word0 leaves, so every
   // write committed before that phase is seen
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         pv_q    <= 3'b000;
         hi_q    <= 1'b0;
         rbuf_q  <= {`DBS_DW{1'b0}};
         rdata_o <= {`DBS_DW{1'b0}};
      end else begin
         if (any_ph) begin
            pv_q    <= {1'b0, pv_q[2:1]};
            pa_q[0] <= pa_q[1];
            pa_q[1] <= pa_q[2];
            hi_q    <= pv_q[0];
            if (pv_q[0]) begin
               {rbuf_q, rdata_o} <= dbs_fetch(pa_q[0]);
            end else if (hi_q) begin
               rdata_o <= rbuf_q;
            end
         end
         // queue the captured read, independent of the write port
         if (rd_go_q) begin
            pv_q[slot_w] <= 1'b1;
            pa_q[slot_w] <= rd_addr_q;
         end
      end
   end

   // ************************************************************
   // echo clocks follow the output clock pair
   // ************************************************************
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         echo_strobe_pair_o   <= 1'b0;
         echo_strobe_pair_n_o <= 1'b1;
      end else if (o_rise) begin
         echo_strobe_pair_o   <= 1'b1;
         echo_strobe_pair_n_o <= 1'b0;
      end else if (on_rise) begin
         echo_strobe_pair_o   <= 1'b0;
         echo_strobe_pair_n_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: logic/dbs_consts.vh
// constants for the two-port double-data-rate burst sram model
// assumes inclusion by bare name from the design files
`ifndef DBS_CONSTS_VH
`define DBS_CONSTS_VH
// ************************************************************
// widths
// ************************************************************
`define DBS_DW        18      // data word width (8, 9, 18 or 36)
`define DBS_AW        6       // burst address width (model depth)
`define DBS_DEPTH     64      // burst locations held
// ************************************************************
// latency selection
// ************************************************************
`define DBS_LAT_FULL  2'd3    // half-cycle phases, bypass high (1.5)
`define DBS_LAT_SHORT 2'd2    // half-cycle phases, bypass low (1)
`endif

// file: logic/dbs_edge_sync.v
// two-flop synchroniser with rising-edge pulse for one link clock
// assumes the input is asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module dbs_edge_sync (
   input  wire clk_i,     // system clock
   input  wire rst_b_i,   // synchronous reset, active low
   input  wire async_i,   // pin from outside the domain
   output reg  rise_o     // one-cycle pulse on a rising edge
);
   reg meta_q;            // first stage, read only by sync_q
   reg sync_q;            // second stage
   reg last_q;            // previous synced value

   // ************************************************************
   // sync chain and edge detect
   // ************************************************************
   // all stages reset high: no false edge whatever the pin idles at
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         last_q <= 1'b1;
         rise_o <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         last_q <= sync_q;
         rise_o <= sync_q & ~last_q;
      end
   end
endmodule
`default_nettype wire

// file: test/dbs_sram_props.sv
// port checker for the two-port burst sram
// assumes a bind onto dbs_sram and a link pair slower than clk_i
`timescale 1ns/1ns
`default_nettype none
`include "dbs_consts.vh"
module dbs_sram_props (
   input wire logic               clk_i,        // system clock
   input wire logic               rst_b_i,      // sync reset, low
   input wire logic               kclk_i,       // input clock
   input wire logic               kclk_n_i,     // input complement
   input wire logic               cclk_i,       // output clock
   input wire logic               cclk_n_i,     // output complement
   input wire logic               single_clk_i, // k pair times output
   input wire logic               pll_bypass_i, // latency select
   input wire logic               rd_sel_b_i,   // read select, low
   input wire logic               wr_sel_b_i,   // write select, low
   input wire logic [`DBS_DW-1:0] rdata_o,      // read data
   input wire logic               echo_strobe_pair_o,  // echo clock
   input wire logic               echo_strobe_pair_n_o // echo complement
);
   // ****
   // helper ages
   // ****
   wire logic  oc  = single_clk_i ? kclk_i : cclk_i;     // output clock
   wire logic  ocn = single_clk_i ? kclk_n_i : cclk_n_i; // its complement
   logic       oc_q, ocn_q, k_q; // last pin samples
   logic [3:0] rise_q;           // clk edges since an output rise
   logic [3:0] rd_q;             // k rises since a captured read
   wire logic  orise = (oc & ~oc_q) | (ocn & ~ocn_q);
   // sample pins, age counters saturate at 15
   always_ff @(posedge clk_i) begin
      oc_q  <= oc;
      ocn_q <= ocn;
      k_q   <= kclk_i;
      if (!rst_b_i) begin
         rise_q <= 4'hf;
         rd_q   <= 4'hf;
      end else begin
         if (orise) rise_q <= 4'h0;
         else if (rise_q != 4'hf) rise_q <= rise_q + 4'h1;
         if (kclk_i & ~k_q & !rd_sel_b_i) rd_q <= 4'h0;
         else if (kclk_i & ~k_q & rd_q != 4'hf) rd_q <= rd_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_RST_VALUES: assert property (disable iff (1'b0)
      !rst_b_i |=> rdata_o == '0 && !echo_strobe_pair_o
      && echo_strobe_pair_n_o) else $error("outputs off reset values");
   AST_ECHO_PAIR: assert property (
      echo_strobe_pair_n_o == !echo_strobe_pair_o)
      else $error("echo pair not complementary");
   AST_ECHO_FOLLOWS: assert property (
      orise |-> ##[1:8] $changed(echo_strobe_pair_o))
      else $error("echo missed an output rise");
   AST_ECHO_ON_RISE: assert property (
      $changed(echo_strobe_pair_o) |-> rise_q <= 4'd6)
      else $error("echo moved without an output rise");
   AST_ECHO_SPACING: assert property (
      $changed(echo_strobe_pair_o) |=> $stable(echo_strobe_pair_o) [*3])
      else $error("echo moved twice in one half period");
   AST_RDATA_ON_RISE: assert property (
      $changed(rdata_o) |-> rise_q <= 4'd6)
      else $error("read data moved without an output rise");
   AST_RDATA_SPACING: assert property (
      $changed(rdata_o) |=> $stable(rdata_o) [*3])
      else $error("read data moved twice in one half period");
   AST_RDATA_AFTER_READ: assert property (
      $changed(rdata_o) |-> rd_q <= 4'd2)
      else $error("read data moved after the burst ended");
   cover property ($rose(kclk_i) && !rd_sel_b_i && pll_bypass_i);
   cover property ($rose(kclk_i) && !rd_sel_b_i && !pll_bypass_i);
   cover property ($rose(kclk_n_i) && !wr_sel_b_i && single_clk_i);
endmodule
`default_nettype wire

// file: test/dbs_ctl_model.sv
// controller model: link clocks, shared address, selects, write data
// assumes the bench calls kcycle back to back while traffic runs
`timescale 1ns/1ns
`default_nettype none
`include "dbs_consts.vh"
module dbs_ctl_model (
   input  wire logic               c_stuck_i,  // output pair held still
   output var  logic               kclk_o,     // input clock
   output var  logic               kclk_n_o,   // input complement
   output var  logic               cclk_o,     // output clock
   output var  logic               cclk_n_o,   // output complement
   output var  logic [`DBS_AW-1:0] addr_o,     // shared address
   output var  logic               rd_sel_b_o, // read select, low
   output var  logic               wr_sel_b_o, // write select, low
   output var  logic [`DBS_DW-1:0] wdata_o     // write data
);
   // ****
   // one input clock period per call
   // ****
   logic               pend;     // write burst still owed
   logic [`DBS_DW-1:0] pw0, pw1; // owed words
   time                k_time;   // last k rise
   // both pairs move together unless the output pair is held
   task automatic pair(input logic v);
      kclk_o   = v;
      kclk_n_o = ~v;
      cclk_o   = v & ~c_stuck_i;
      cclk_n_o = ~v | c_stuck_i;
   endtask
   initial begin
      pair(1'b0);
      addr_o     = '0;
      rd_sel_b_o = 1'b1;
      wr_sel_b_o = 1'b1;
      wdata_o    = '0;
      pend       = 1'b0;
   end
   // released lines show the inverse of their last value
   task automatic kcycle(input logic rd, wr,
      input logic [`DBS_AW-1:0] ra, wa, input logic [`DBS_DW-1:0] w0, w1);
      addr_o     = rd ? ra : ~addr_o;
      rd_sel_b_o = ~rd;
      wdata_o    = pend ? pw0 : ~wdata_o;
      #40 pair(1'b1);
      k_time     = $time;
      #40 addr_o = wr ? wa : ~addr_o;
      wr_sel_b_o = ~wr;
      wdata_o    = pend ? pw1 : ~wdata_o;
      #40 pair(1'b0);
      #40 pend   = wr;
      pw0        = w0;
      pw1        = w1;
   endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the two-port burst sram
// assumes dbs_sram, dbs_ctl_model and dbs_sram_props compiled first
`timescale 1ns/1ns
`default_nettype none
`include "dbs_consts.vh"
module testbench;
   // ****
   // pins, counters, expected contents
   // ****
   logic                clk_i, rst_b_i, single_clk_i, pll_bypass_i;
   wire logic           kc, kcn, cc, ccn, rsel, wsel, echo, echo_n;
   wire logic [`DBS_AW-1:0] addr;         // shared address
   wire logic [`DBS_DW-1:0] wdata, rdata; // data buses
   logic [`DBS_AW-1:0]  a;                // corner address
   integer              error_cnt, total_checks, seed, i, t;
   logic [`DBS_DW-1:0]  m0 [0:`DBS_DEPTH-1]; // expected first words
   logic [`DBS_DW-1:0]  m1 [0:`DBS_DEPTH-1]; // expected second words
   dbs_sram uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .kclk_i(kc),
      .kclk_n_i(kcn), .cclk_i(cc), .cclk_n_i(ccn), .addr_i(addr),
      .single_clk_i(single_clk_i), .pll_bypass_i(pll_bypass_i),
      .rd_sel_b_i(rsel), .wr_sel_b_i(wsel), .wdata_i(wdata),
      .rdata_o(rdata), .echo_strobe_pair_o(echo),
      .echo_strobe_pair_n_o(echo_n));
   dbs_ctl_model ctl (.c_stuck_i(single_clk_i), .kclk_o(kc),
      .kclk_n_o(kcn), .cclk_o(cc), .cclk_n_o(ccn), .addr_o(addr),
      .rd_sel_b_o(rsel), .wr_sel_b_o(wsel), .wdata_o(wdata));
   // output rise that carries the first word
   function automatic integer first_rise(input logic byp);
      first_rise = byp ? 3 : 2;
   endfunction
   task automatic check_word(input logic [`DBS_DW-1:0] got, exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("unexpected at %0t: rdata %h, want %h", $time, got, exp);
      end
   endtask
   task automatic check_echo(input logic got, got_n, exp);
      total_checks = total_checks + 1;
      if (got !== exp || got_n !== ~exp) begin
         error_cnt = error_cnt + 1;
         $display("unexpected at %0t: echo %b%b, want %b", $time,
            got, got_n, exp);
      end
   endtask
   // look mid-way through the half period each word stands in
   task automatic watch(input time t0, input integer n,
      input logic [`DBS_DW-1:0] e0, e1);
      #(t0 + n * 80 + 140 - $time);
      check_word(rdata, e0);
      check_echo(echo, echo_n, ~n[0]);
      #80 check_word(rdata, e1);
      check_echo(echo, echo_n, n[0]);
   endtask
   // one k period; expectation taken before this period's write
   task automatic op(input logic rd, wr, input logic [`DBS_AW-1:0] ra, wa);
      logic [`DBS_DW-1:0] e0, e1, w0, w1;
      time                tk;
      integer             nr;
      e0 = m0[ra];
      e1 = m1[ra];
      w0 = `DBS_DW'($random(seed));
      w1 = `DBS_DW'($random(seed));
      ctl.kcycle(rd, wr, ra, wa, w0, w1);
      tk = ctl.k_time;
      nr = first_rise(pll_bypass_i);
      if (rd) fork
         watch(tk, nr, e0, e1);
      join_none
      if (wr) begin
         m0[wa] = w0;
         m1[wa] = w1;
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      #400000 error_cnt = error_cnt + 1;
      $display("unexpected at %0t: run hung", $time);
      tally_and_finish;
   end
   initial begin
      seed         = 32'hb463;
      error_cnt    = 0;
      total_checks = 0;
      rst_b_i      = 1'b0;
      single_clk_i = 1'b0;
      pll_bypass_i = 1'b1;
      repeat (12) @(posedge clk_i);
      #2 rst_b_i = 1'b1;
      check_word(rdata, '0);
      check_echo(echo, echo_n, 1'b0);
      repeat (4) @(posedge clk_i);
      // link pins move a fixed 2 ns after a clock edge from here on
      #2;
      // fill every location so later reads are known
      for (i = 0; i < `DBS_DEPTH; i = i + 1)
         op(1'b0, 1'b1, '0, i[`DBS_AW-1:0]);
      $display("test fill done, mismatches %0d", error_cnt);
      // every latency and clock mode: coherency corner, random mix
      for (t = 0; t < 4; t = t + 1) begin
         repeat (3) op(1'b0, 1'b0, '0, '0);
         @(posedge clk_i);
         #2 {single_clk_i, pll_bypass_i} = t[1:0];
         a = `DBS_AW'($random(seed));
         op(1'b0, 1'b1, a, a);
         op(1'b1, 1'b1, a, a);
         op(1'b1, 1'b0, a, a);
         repeat (40) op(1'($random(seed)), 1'($random(seed)),
            `DBS_AW'($random(seed)), `DBS_AW'($random(seed)));
         $display("test mode %0d done, mismatches %0d", t, error_cnt);
      end
      repeat (3) op(1'b0, 1'b0, '0, '0);
      tally_and_finish;
   end
endmodule
bind dbs_sram dbs_sram_props chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .kclk_i(kclk_i), .kclk_n_i(kclk_n_i), .cclk_i(cclk_i),
   .cclk_n_i(cclk_n_i), .single_clk_i(single_clk_i),
   .pll_bypass_i(pll_bypass_i), .rd_sel_b_i(rd_sel_b_i),
   .wr_sel_b_i(wr_sel_b_i), .rdata_o(rdata_o),
   .echo_strobe_pair_o(echo_strobe_pair_o),
   .echo_strobe_pair_n_o(echo_strobe_pair_n_o));
`default_nettype wire
